// ### rtl/aor_map.svh
/*
  Register offsets, reset values and timing counts of the assignable
  output router. Assumes a 125 MHz system clock and byte addressing.
*/
`ifndef AOR_MAP_SVH
`define AOR_MAP_SVH

`define AOR_OFS_SEL 8'h00
`define AOR_OFS_FUNC 8'h04
`define AOR_OFS_POL 8'h08
`define AOR_OFS_DLY 8'h0c
`define AOR_OFS_STAT 8'h10
`define AOR_OFS_IRQ_STS 8'h14
`define AOR_OFS_IRQ_CLR 8'h18
`define AOR_OFS_IRQ_EN 8'h1c
`define AOR_OFS_THR_SPD 8'h20
`define AOR_OFS_THR_SET 8'h24
`define AOR_OFS_THR_ARM 8'h28
`define AOR_OFS_THR_FLD 8'h2c
`define AOR_OFS_HYST 8'h30

`define AOR_NUM_OUT 13
`define AOR_NUM_TERM 5
`define AOR_RELAY_SEL 5'h0d
`define AOR_SEL_DEF 5'h01
`define AOR_FUNC_MAX 5'h14

`define AOR_DEF_F1 5'h01
`define AOR_DEF_F2 5'h03
`define AOR_DEF_F3 5'h09
`define AOR_DEF_F4 5'h0b
`define AOR_DEF_F5 5'h0a
`define AOR_DEF_F6 5'h07
`define AOR_DEF_F7 5'h08
`define AOR_DEF_F8 5'h0c
`define AOR_DEF_F9 5'h0d
`define AOR_DEF_F10 5'h02
`define AOR_DEF_F11 5'h04
`define AOR_DEF_F12 5'h05
`define AOR_DEF_F13 5'h06
`define AOR_DEF_POL 13'h1009

`define AOR_CLK_MHZ 125
`define AOR_TICK_US 1000
`define AOR_TICK_CYC (`AOR_TICK_US * `AOR_CLK_MHZ)
`define AOR_DLY_MAX_S 240
`define AOR_DLY_MAX_MS (`AOR_DLY_MAX_S * 1000)

`endif

// ### rtl/aor_pkg.sv
/*
  Types shared by the assignable output router files.
  Assumes nothing beyond the map header.
*/
package aor_pkg;
  typedef logic [4:0] aor_func_t;
  typedef logic [17:0] aor_ms_t;
  typedef logic [12:0] aor_vec_t;
  typedef logic [15:0] aor_mag_t;
endpackage

// ### rtl/aor_delay.sv
/*
  Turn-on/turn-off delay filter for one output.
  Assumes a one-cycle millisecond tick from the same clock.
*/
`timescale 1ns/1ps
`include "aor_map.svh"
module aor_delay
  import aor_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic d_i,
  input wire aor_ms_t dly_i,
  output logic q_o
);
  aor_ms_t cnt_r;
  logic q_r;

  assign q_o = q_r;

  // (R17) restart on change
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
      q_r <= 1'b0;
    end else if (d_i == q_r) begin
      cnt_r <= '0;
    end else if (cnt_r >= dly_i) begin
      q_r <= d_i;
      cnt_r <= '0;
    end else if (tick_i) begin
      cnt_r <= cnt_r + 18'h00001;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_dly_hold;
    $changed(q_r) |-> $past(cnt_r) >= $past(dly_i);
  endproperty
  a_dly_hold: assert property (p_dly_hold) else $error("output moved before delay"); // (R12)

  property p_dly_restart;
    (d_i == q_r) |=> (cnt_r == 18'h00000);
  endproperty
  a_dly_restart: assert property (p_dly_restart) else $error("delay count not restarted"); // (R17)
endmodule

// ### rtl/aor_top.sv
/*
  Assignable output router: thirteen outputs, each fed by a selectable
  drive status function, with polarity and delay on the terminal and
  relay outputs, configured over AXI4-Lite.
  Assumes drive status and magnitudes come from logic on ref_clk_i.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
// How it works
// (R1) select 1..12 outputs, 13 relay, default 1
// (R2) one function may feed many outputs
// (R3) outputs 1..5 drive terminals, 6..12 none
// (R4) outputs 6..12 only in status word
// (R5) polarity, delay only on 1..5 and relay
// (R6) code 0 constant inactive, others status
// (R7) codes 14..17 magnitude above threshold
// (R8) 18 brake, 19 and 20 comparators
// (R9) factory default function routing
// (R10) polarity 0 high active, 1 low
// (R11) default low active on 1, 4, relay
// (R12) delay 0 to 240 s, 1 ms steps
// (R13) thresholds switch off with hysteresis
// (R14) host writes select, function, polarity, delay
// (R15) status shows active as one
// (R16) status bits 0..12, upper bits zero
// (R17) delay restarts on each input change
// (R18) reset drives inactive levels, clears delays
`timescale 1ns/1ps
`include "aor_map.svh"
module aor_top
  import aor_pkg::*;
#(
  parameter int MS_CYCLES = `AOR_TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] drive_status_i,
  input wire logic brake_ctrl_i,
  input wire logic cmp1_i,
  input wire logic cmp2_i,
  input wire aor_mag_t setpoint_mag_i,
  input wire aor_mag_t arm_current_i,
  input wire aor_mag_t field_current_i,
  input wire aor_mag_t speed_mag_i,
  output logic [4:0] term_o,
  output logic relay_o,
  output logic irq_o
);
  localparam aor_vec_t DEF_POL = `AOR_DEF_POL;
  localparam logic [16:0] TICK_LAST = 17'(MS_CYCLES - 1);
  localparam logic [31:0] DLY_MAX = 32'(`AOR_DLY_MAX_MS);

  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] awaddr_r, rdaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  logic [31:0] wval;
  logic [32:0] aw_word, ar_word;

  aor_func_t out_sel_r;
  aor_func_t func_tab_r [0:12];
  aor_vec_t pol_r;
  aor_ms_t dly_tab_r [0:5];
  aor_mag_t thr_r [0:3];
  aor_mag_t hyst_r;
  logic [4:0] flag_r;
  logic [16:0] tick_cnt_r;
  logic tick_r;
  aor_vec_t raw;
  logic [5:0] dq;
  aor_vec_t st_nxt, st_r, irq_sts_r, irq_en_r;
  logic [4:0] term_r;
  logic relay_r, irq_r;

  function automatic logic hys_above(input logic st, input aor_mag_t m, input aor_mag_t t,
                                     input aor_mag_t h);
    if (st) begin
      hys_above = ({1'b0, m} + {1'b0, h}) > {1'b0, t};
    end else begin
      hys_above = m > t;
    end
  endfunction

  function automatic logic hys_below(input logic st, input aor_mag_t m, input aor_mag_t t,
                                     input aor_mag_t h);
    if (st) begin
      hys_below = {1'b0, m} < ({1'b0, t} + {1'b0, h});
    end else begin
      hys_below = m < t;
    end
  endfunction

  function automatic logic src_bit(input aor_func_t code, input logic [4:0] flg,
                                   input logic [11:0] ds, input logic [2:0] ext);
    case (code)
      5'h00: src_bit = 1'b0;
      5'h01: src_bit = flg[0];
      5'h0e: src_bit = flg[1];
      5'h0f: src_bit = flg[2];
      5'h10: src_bit = flg[3];
      5'h11: src_bit = flg[4];
      5'h12: src_bit = ext[0];
      5'h13: src_bit = ext[1];
      5'h14: src_bit = ext[2];
      default: src_bit = (code >= 5'h02 && code <= 5'h0d) ? ds[4'(code - 5'h02)] : 1'b0;
    endcase
  endfunction

  // delay slot of an output index, 7 when it has none
  function automatic logic [2:0] dly_slot(input aor_func_t sel);
    if (sel >= 5'h01 && sel <= 5'(`AOR_NUM_TERM)) begin
      dly_slot = 3'(sel - 5'h01);
    end else if (sel == `AOR_RELAY_SEL) begin
      dly_slot = 3'h5;
    end else begin
      dly_slot = 3'h7;
    end
  endfunction

  function automatic aor_func_t def_func(input int i);
    case (i)
      0: def_func = `AOR_DEF_F1;
      1: def_func = `AOR_DEF_F2;
      2: def_func = `AOR_DEF_F3;
      3: def_func = `AOR_DEF_F4;
      4: def_func = `AOR_DEF_F5;
      5: def_func = `AOR_DEF_F6;
      6: def_func = `AOR_DEF_F7;
      7: def_func = `AOR_DEF_F8;
      8: def_func = `AOR_DEF_F9;
      9: def_func = `AOR_DEF_F10;
      10: def_func = `AOR_DEF_F11;
      11: def_func = `AOR_DEF_F12;
      default: def_func = `AOR_DEF_F13;
    endcase
  endfunction

  function automatic logic [32:0] rd_word(input logic [7:0] a);
    logic [2:0] s;
    s = dly_slot(out_sel_r);
    rd_word = 33'h000000000;
    case (a)
      `AOR_OFS_SEL: rd_word[4:0] = out_sel_r;
      `AOR_OFS_FUNC: rd_word[4:0] = func_tab_r[4'(out_sel_r - 5'h01)];
      `AOR_OFS_POL: rd_word[0] = pol_r[4'(out_sel_r - 5'h01)];
      `AOR_OFS_DLY: rd_word[17:0] = (s == 3'h7) ? 18'h00000 : dly_tab_r[s];
      `AOR_OFS_STAT: rd_word[12:0] = st_r;
      `AOR_OFS_IRQ_STS: rd_word[12:0] = irq_sts_r;
      `AOR_OFS_IRQ_CLR: rd_word = 33'h000000000;
      `AOR_OFS_IRQ_EN: rd_word[12:0] = irq_en_r;
      `AOR_OFS_THR_SPD: rd_word[15:0] = thr_r[0];
      `AOR_OFS_THR_SET: rd_word[15:0] = thr_r[1];
      `AOR_OFS_THR_ARM: rd_word[15:0] = thr_r[2];
      `AOR_OFS_THR_FLD: rd_word[15:0] = thr_r[3];
      `AOR_OFS_HYST: rd_word[15:0] = hyst_r;
      default: rd_word[32] = 1'b1;
    endcase
  endfunction

  // write address and data taken in either order
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      awready_r <= 1'b1;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end else if (bvalid_r && s_axi_bready) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wready_r <= 1'b1;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (bvalid_r && s_axi_bready) begin
      wready_r <= 1'b1;
    end
  end

  assign do_wr = !awready_r && !wready_r && !bvalid_r;

  always_comb begin
    aw_word = rd_word(awaddr_r);
    ar_word = rd_word(s_axi_araddr);
  end

  always_comb begin
    logic [31:0] m;
    m = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wval = (aw_word[31:0] & ~m) | (wdata_r & m);
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= aw_word[32] ? 2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'b00;
      rdaddr_r <= 8'h00;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= ar_word[31:0];
      rresp_r <= ar_word[32] ? 2'b10 : 2'b00;
      rdaddr_r <= s_axi_araddr;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // (R1) output index range
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_sel_r <= `AOR_SEL_DEF;
    end else if (do_wr && awaddr_r == `AOR_OFS_SEL && wval[31:0] >= 32'h1 &&
                 wval[31:0] <= 32'(`AOR_NUM_OUT)) begin
      out_sel_r <= wval[4:0];
    end
  end

  // (R9) factory routing table
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < `AOR_NUM_OUT; i++) begin
        func_tab_r[i] <= def_func(i);
      end
    end else if (do_wr && awaddr_r == `AOR_OFS_FUNC && wval[31:0] <= 32'(`AOR_FUNC_MAX)) begin
      // (R2) no uniqueness check
      func_tab_r[4'(out_sel_r - 5'h01)] <= wval[4:0];
    end
  end

  // (R11) default polarity
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pol_r <= DEF_POL;
    end else if (do_wr && awaddr_r == `AOR_OFS_POL && dly_slot(out_sel_r) != 3'h7) begin
      // (R5) polarity only where a pin exists
      pol_r[4'(out_sel_r - 5'h01)] <= wval[0];
    end
  end

  // (R12) delay range in ms
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 6; i++) begin
        dly_tab_r[i] <= 18'h00000;
      end
    end else if (do_wr && awaddr_r == `AOR_OFS_DLY && dly_slot(out_sel_r) != 3'h7 &&
                 wval[31:0] <= DLY_MAX) begin
      dly_tab_r[dly_slot(out_sel_r)] <= wval[17:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 4; i++) begin
        thr_r[i] <= 16'h0000;
      end
      hyst_r <= 16'h0000;
    end else if (do_wr) begin
      case (awaddr_r)
        `AOR_OFS_THR_SPD: thr_r[0] <= wval[15:0];
        `AOR_OFS_THR_SET: thr_r[1] <= wval[15:0];
        `AOR_OFS_THR_ARM: thr_r[2] <= wval[15:0];
        `AOR_OFS_THR_FLD: thr_r[3] <= wval[15:0];
        `AOR_OFS_HYST: hyst_r <= wval[15:0];
        default: hyst_r <= hyst_r;
      endcase
    end
  end

  // (R13) hysteresis comparators
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_r <= 5'h00;
    end else begin
      flag_r[0] <= hys_below(flag_r[0], speed_mag_i, thr_r[0], hyst_r);
      // (R7) magnitude over threshold
      flag_r[1] <= hys_above(flag_r[1], setpoint_mag_i, thr_r[1], hyst_r);
      flag_r[2] <= hys_above(flag_r[2], arm_current_i, thr_r[2], hyst_r);
      flag_r[3] <= hys_above(flag_r[3], field_current_i, thr_r[3], hyst_r);
      flag_r[4] <= hys_above(flag_r[4], speed_mag_i, thr_r[0], hyst_r);
    end
  end

  // millisecond tick
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_r <= 17'h00000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= TICK_LAST) begin
      tick_cnt_r <= 17'h00000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h00001;
      tick_r <= 1'b0;
    end
  end

  // (R6) (R8) source selection
  always_comb begin
    for (int i = 0; i < `AOR_NUM_OUT; i++) begin
      raw[i] = src_bit(func_tab_r[i], flag_r, drive_status_i, {cmp2_i, cmp1_i, brake_ctrl_i});
    end
  end

  for (genvar g = 0; g < 6; g++) begin : g_dly
    aor_delay i_aor_delay (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .tick_i(tick_r),
      .d_i(raw[(g < 5) ? g : 12]),
      .dly_i(dly_tab_r[g]),
      .q_o(dq[g])
    );
  end

  // (R15) (R16) status word
  assign st_nxt = {dq[5], raw[11:5], dq[4:0]};

  // (R18) (R10) pins from polarity
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= 13'h0000;
      term_r <= DEF_POL[4:0];
      relay_r <= DEF_POL[12];
    end else begin
      st_r <= st_nxt;
      // (R3) (R4) only five terminals
      term_r <= dq[4:0] ^ pol_r[4:0];
      relay_r <= dq[5] ^ pol_r[12];
    end
  end

  // sticky status, set beats clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_sts_r <= 13'h0000;
      irq_en_r <= 13'h0000;
      irq_r <= 1'b0;
    end else begin
      if (do_wr && awaddr_r == `AOR_OFS_IRQ_EN) begin
        irq_en_r <= wval[12:0];
      end
      if (do_wr && awaddr_r == `AOR_OFS_IRQ_CLR) begin
        irq_sts_r <= (irq_sts_r & ~wval[12:0]) | (st_nxt & ~st_r);
      end else begin
        irq_sts_r <= irq_sts_r | (st_nxt & ~st_r);
      end
      irq_r <= |(irq_sts_r & irq_en_r);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign term_o = term_r;
  assign relay_o = relay_r;
  assign irq_o = irq_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_sel_range;
    (out_sel_r >= 5'h01) && (out_sel_r <= 5'h0d);
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("output index out of range"); // (R1)

  property p_multi;
    (func_tab_r[5] == func_tab_r[6]) |-> (raw[5] == raw[6]);
  endproperty
  a_multi: assert property (p_multi) else $error("shared function differs"); // (R2)

  property p_free_nodly;
    raw[7] |=> st_r[7];
  endproperty
  a_free_nodly: assert property (p_free_nodly) else $error("free output delayed"); // (R5)

  property p_nofunc;
    (func_tab_r[8] == 5'h00) |=> !st_r[8];
  endproperty
  a_nofunc: assert property (p_nofunc) else $error("code zero active"); // (R6)

  property p_pol;
    dq[0] |=> (term_r[0] == !$past(pol_r[0]));
  endproperty
  a_pol: assert property (p_pol) else $error("terminal level wrong"); // (R10)

  property p_hyst;
    (flag_r[2] && ({1'b0, arm_current_i} + {1'b0, hyst_r}) > {1'b0, thr_r[2]}) |=> flag_r[2];
  endproperty
  a_hyst: assert property (p_hyst) else $error("threshold dropped early"); // (R13)

  property p_upper;
    (rvalid_r && rdaddr_r == `AOR_OFS_STAT) |-> (rdata_r[31:13] == 19'h00000);
  endproperty
  a_upper: assert property (p_upper) else $error("status upper bits set"); // (R16)

  property p_relay_stat;
    dq[5] |=> (st_r[12] && (relay_r == !$past(pol_r[12])));
  endproperty
  a_relay_stat: assert property (p_relay_stat) else $error("relay status wrong"); // (R15)
endmodule

// ### verification/aor_load_model.sv
/*
  Load model: sinking lamps on the five terminals and a relay coil.
  Assumes the pins are sampled on the system clock.
*/
`timescale 1ns/1ps
module aor_load_model (
  input wire logic ref_clk_i,
  input wire logic [4:0] term_i,
  input wire logic relay_i,
  output logic [4:0] lamp_o,
  output logic coil_o
);
  // loads are energized while the pin is low
  always_ff @(posedge ref_clk_i) begin
    lamp_o <= ~term_i;
    coil_o <= ~relay_i;
  end
endmodule

// ### verification/assignable_output_router_tb_top.sv
/*
  Self-checking bench of the assignable output router.
  Assumes the design files and the load model are compiled first.
*/
`timescale 1ns/1ps
`include "aor_map.svh"
module assignable_output_router_tb_top;
  logic ref_clk_i, rstn_i;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] drive_status_i;
  logic brake_ctrl_i, cmp1_i, cmp2_i, relay_o, irq_o, coil;
  logic [15:0] setpoint_mag_i, arm_current_i, field_current_i, speed_mag_i;
  logic [4:0] term_o, lamp;
  logic [31:0] d;
  logic [1:0] r;
  int err_count, n_tests;

  aor_top #(.MS_CYCLES(10)) i_aor_top (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .drive_status_i(drive_status_i),
    .brake_ctrl_i(brake_ctrl_i), .cmp1_i(cmp1_i), .cmp2_i(cmp2_i),
    .setpoint_mag_i(setpoint_mag_i), .arm_current_i(arm_current_i),
    .field_current_i(field_current_i), .speed_mag_i(speed_mag_i), .term_o(term_o),
    .relay_o(relay_o), .irq_o(irq_o));
  aor_load_model i_aor_load_model (.ref_clk_i(ref_clk_i), .term_i(term_o),
    .relay_i(relay_o), .lamp_o(lamp), .coil_o(coil));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang();
    err_count++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    finish_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad, wd, bd;
    ad = 0;
    wd = 0;
    bd = 0;
    rs = 2'h3;
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !bd; n++) begin
      @(negedge ref_clk_i);
      if (s_axi_awvalid && s_axi_awready) ad = 1;
      if (s_axi_wvalid && s_axi_wready) wd = 1;
      if (s_axi_bvalid && s_axi_bready) begin
        bd = 1;
        rs = s_axi_bresp;
      end
      @(posedge ref_clk_i);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
      if (bd) s_axi_bready <= 1'b0;
    end
    if (!bd) hang();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ad, dd;
    ad = 0;
    dd = 0;
    rs = 2'h3;
    v = '0;
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !dd; n++) begin
      @(negedge ref_clk_i);
      if (s_axi_arvalid && s_axi_arready) ad = 1;
      if (s_axi_rvalid && s_axi_rready) begin
        dd = 1;
        v = s_axi_rdata;
        rs = s_axi_rresp;
      end
      @(posedge ref_clk_i);
      if (ad) s_axi_arvalid <= 1'b0;
      if (dd) s_axi_rready <= 1'b0;
    end
    if (!dd) hang();
  endtask

  task automatic put(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    wr(a, v, rs);
  endtask

  task automatic get(input logic [7:0] a, output logic [31:0] v);
    logic [1:0] rs;
    rd(a, v, rs);
  endtask

  task automatic cfg(input logic [31:0] s, input logic [31:0] f);
    put(`AOR_OFS_SEL, s);
    put(`AOR_OFS_FUNC, f);
  endtask

  // sources as {cmp2, cmp1, brake, drive status}
  task automatic src(input logic [14:0] v);
    @(posedge ref_clk_i);
    {cmp2_i, cmp1_i, brake_ctrl_i, drive_status_i} <= v;
    repeat (4) @(posedge ref_clk_i);
  endtask

  task automatic mags(input logic [15:0] v);
    @(posedge ref_clk_i);
    {setpoint_mag_i, arm_current_i, field_current_i, speed_mag_i} <= {4{v}};
    repeat (4) @(posedge ref_clk_i);
  endtask

  task automatic t_reset();
    repeat (8) @(posedge ref_clk_i);
    chk(term_o, 5'h09);
    chk(relay_o, 1'b1);
    rstn_i <= 1'b1;
    get(`AOR_OFS_SEL, d);
    chk(d, 32'h1);
    for (int s = 1; s <= 13; s += (s == 5) ? 8 : 1) begin
      put(`AOR_OFS_SEL, s);
      get(`AOR_OFS_POL, d);
      chk(d, (s == 1 || s == 4 || s == 13) ? 32'h1 : 32'h0);
      get(`AOR_OFS_DLY, d);
      chk(d, 32'h0);
    end
  endtask

  task automatic t_default();
    src(15'h007d);
    get(`AOR_OFS_STAT, d);
    chk(d & 32'h1e7e, 32'h1e60);
    chk(relay_o, 1'b0);
  endtask

  task automatic t_route();
    int idx;
    for (int c = 0; c <= 20; c++) begin
      if (c == 1 || (c >= 14 && c <= 17)) continue;
      cfg(9, c);
      idx = (c <= 13) ? c - 2 : c - 6;
      src(c == 0 ? 15'h7fff : 15'h1 << idx);
      get(`AOR_OFS_STAT, d);
      chk(d[8], c != 0);
      src(c == 0 ? 15'h0 : ~(15'h1 << idx));
      get(`AOR_OFS_STAT, d);
      chk(d[8], 1'b0);
    end
  endtask

  task automatic t_share();
    src(15'h0);
    cfg(6, 19);
    put(`AOR_OFS_POL, 1);
    get(`AOR_OFS_POL, d);
    chk(d, 32'h0);
    cfg(7, 19);
    cfg(13, 19);
    cfg(3, 19);
    put(`AOR_OFS_POL, 0);
    src(15'h2000);
    get(`AOR_OFS_STAT, d);
    chk(d & 32'hfffffffe, 32'h1064);
    chk(term_o[4:1], 4'b0110);
    chk(relay_o, 1'b0);
    chk(coil, 1'b1);
    put(`AOR_OFS_POL, 1);
    repeat (4) @(posedge ref_clk_i);
    chk(term_o[2], 1'b0);
    chk(lamp[2], 1'b1);
  endtask

  task automatic t_delay();
    cfg(2, 20);
    put(`AOR_OFS_POL, 0);
    put(`AOR_OFS_DLY, 240001);
    get(`AOR_OFS_DLY, d);
    chk(d, 32'h0);
    put(`AOR_OFS_DLY, 240000);
    get(`AOR_OFS_DLY, d);
    chk(d, 32'd240000);
    put(`AOR_OFS_DLY, 3);
    src(15'h4000);
    repeat (11) @(posedge ref_clk_i);
    chk(term_o[1], 1'b0);
    repeat (40) @(posedge ref_clk_i);
    chk(term_o[1], 1'b1);
    repeat (4) begin
      src(15'h0);
      repeat (14) @(posedge ref_clk_i);
      src(15'h4000);
    end
    chk(term_o[1], 1'b1);
  endtask

  task automatic t_thr();
    for (int i = 0; i < 4; i++) put(8'(`AOR_OFS_THR_SPD + 4 * i), 100);
    put(`AOR_OFS_HYST, 10);
    for (int c = 14; c <= 17; c++) begin
      cfg(8, c);
      mags(16'd200);
      get(`AOR_OFS_STAT, d);
      chk(d[7], 1'b1);
      mags(16'd0);
      get(`AOR_OFS_STAT, d);
      chk(d[7], 1'b0);
    end
    cfg(8, 15);
    mags(16'd101);
    mags(16'd95);
    get(`AOR_OFS_STAT, d);
    chk(d[7], 1'b1);
    mags(16'd90);
    get(`AOR_OFS_STAT, d);
    chk(d[7], 1'b0);
    mags(16'd105);
    get(`AOR_OFS_STAT, d);
    chk(d[0], 1'b1);
    mags(16'd110);
    get(`AOR_OFS_STAT, d);
    chk(d[0], 1'b0);
  endtask

  task automatic t_irq();
    cfg(9, 19);
    src(15'h0);
    put(`AOR_OFS_IRQ_CLR, 32'h1fff);
    put(`AOR_OFS_IRQ_EN, 32'h100);
    src(15'h2000);
    chk(irq_o, 1'b1);
    get(`AOR_OFS_IRQ_STS, d);
    chk(d[8], 1'b1);
    put(`AOR_OFS_IRQ_CLR, 32'h100);
    repeat (3) @(posedge ref_clk_i);
    chk(irq_o, 1'b0);
    put(`AOR_OFS_IRQ_EN, 0);
    src(15'h0);
    src(15'h2000);
    chk(irq_o, 1'b0);
    get(`AOR_OFS_IRQ_STS, d);
    chk(d[8], 1'b1);
  endtask

  task automatic t_bad();
    wr(8'h40, 32'h5, r);
    chk(r, 2'h2);
    rd(8'h40, d, r);
    chk(d, 32'h0);
    chk(r, 2'h2);
  endtask

  initial begin
    err_count = 0;
    n_tests = 0;
    rstn_i = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cmp2_i, cmp1_i, brake_ctrl_i, drive_status_i} = '0;
    {setpoint_mag_i, arm_current_i, field_current_i, speed_mag_i} = '0;
    t_reset();
    t_default();
    t_route();
    t_share();
    t_delay();
    t_thr();
    t_irq();
    t_bad();
    finish_test();
  end
endmodule
